//--- ascii_output_cmd.sv
// ASCII command interpreter for a one-channel remote output module
`timescale 1ns/1ps
`include "cmd_interp_params.svh"
module ascii_output_cmd
  import cmd_interp_pkg::*;
#(
  parameter logic [7:0] SAFE_VALUE = 8'h00
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] module_addr,
  input  wire logic       unlock_switch,
  input  wire logic [1:0] stored_proto_in,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  input  wire logic       rx_error,
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic      [1:0] active_proto,
  output logic      [1:0] nv_proto_data,
  output logic            nv_proto_write,
  input  wire logic       wdt_timeout,
  output logic            wdt_clear,
  output logic            output_value,
  output logic            relay_drive
);
  state_e     state_reg;
  char_t      buf_reg [`BUF_LEN];
  logic [3:0] len_reg;
  logic       err_reg;
  char_t      tx_buf_reg [`BUF_LEN];
  logic [3:0] tx_len_reg;
  logic [3:0] tx_idx_reg;
  logic [1:0] stored_proto_reg;
  logic       pol_reg;
  logic       out_reg;
  logic       proto_loaded_reg;

  // Hex helpers
  function automatic logic is_hex(input char_t c);
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction : is_hex
  function automatic logic [3:0] hex_val(input char_t c);
    hex_val = (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction : hex_val
  function automatic char_t hex_chr(input logic [3:0] v);
    hex_chr = (v < 4'hA) ? 8'(8'h30 + {4'h0, v}) : 8'(8'h37 + {4'h0, v});
  endfunction : hex_chr

  // Slide switch is asynchronous to clk_sys: two flops before the decode sees it
  logic       unlock_meta_reg;
  logic       unlock_sync_reg;
  always_ff @(posedge clk_sys) begin
    unlock_meta_reg <= unlock_switch;
    unlock_sync_reg <= unlock_meta_reg;
  end
  // Decode of the held frame
  logic       addr_ok;
  logic [7:0] addr_val;
  logic [3:0] data_nib;
  logic [3:0] pol_nib;
  assign addr_ok  = is_hex(buf_reg[1]) && is_hex(buf_reg[2]);
  assign addr_val = {hex_val(buf_reg[1]), hex_val(buf_reg[2])};
  assign data_nib = hex_val(buf_reg[3]);
  assign pol_nib  = hex_val(buf_reg[5]);
  logic for_me;
  assign for_me = addr_ok && addr_val == module_addr;

  // A clean CR hands the frame over; an error on the CR itself also drops it
  logic frame_end;
  assign frame_end = state_reg == ST_RX && rx_valid && rx_data == `CH_CR &&
                     !err_reg && !rx_error;
  // Receive frames; a line error poisons the whole frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      len_reg <= 4'h0;
      err_reg <= 1'b0;
    end else if (state_reg == ST_RX && rx_valid) begin
      if (rx_data == `CH_CR) begin
        len_reg <= 4'h0;
        err_reg <= 1'b0;
      end else if (rx_error || len_reg == 4'(`BUF_LEN)) begin
        err_reg <= 1'b1;
      end else begin
        buf_reg[len_reg[2:0]] <= rx_data;
        len_reg <= len_reg + 4'h1;
      end
    end else if (state_reg == ST_RX && rx_error) begin
      err_reg <= 1'b1;
    end
  end
  logic [3:0] frame_len_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      frame_len_reg <= 4'h0;
    else if (state_reg == ST_RX && rx_valid && rx_data == `CH_CR)
      frame_len_reg <= len_reg;
  end

  // Command execution: build a reply or stay silent
  logic       send;
  char_t      r [`BUF_LEN];
  logic [3:0] rlen;
  logic       set_out, set_pol, save_proto, alive;
  always_comb begin
    send = 1'b0;
    rlen = 4'h0;
    set_out = 1'b0;
    set_pol = 1'b0;
    save_proto = 1'b0;
    alive = 1'b0;
    for (int i = 0; i < `BUF_LEN; i++)
      r[i] = `CH_CR;
    if (buf_reg[0] == `CH_TILDE && frame_len_reg == 4'h3 &&
        buf_reg[1] == `CH_STAR && buf_reg[2] == `CH_STAR) begin
      alive = 1'b1;
    end else if (for_me && frame_len_reg >= 4'h3) begin
      send = 1'b1;
      r[0] = `CH_QUEST;
      r[1] = buf_reg[1];
      r[2] = buf_reg[2];
      rlen = 4'h4;
      case (buf_reg[0])
        `CH_DOLLAR: begin
          if (frame_len_reg == 4'h4 && buf_reg[3] == `CH_P) begin
            r[0] = `CH_BANG;
            r[3] = hex_chr(`PROTO_SUPPORTED);
            r[4] = hex_chr({2'b00, stored_proto_reg});
            rlen = 4'h6;
          end else if (frame_len_reg == 4'h5 && buf_reg[3] == `CH_P) begin
            if (unlock_sync_reg && (buf_reg[4] == 8'h30 || buf_reg[4] == 8'h31 ||
                buf_reg[4] == 8'h33)) begin
              r[0] = `CH_BANG;
              save_proto = 1'b1;
            end
          end else
            send = 1'b0;
        end
        `CH_AT: begin
          if (frame_len_reg == 4'h3) begin
            r[0] = `CH_GT;
            r[1] = hex_chr({3'b000, out_reg});
            rlen = 4'h3;
          end else if (frame_len_reg == 4'h4 && is_hex(buf_reg[3])) begin
            if (wdt_timeout) begin
              r[0] = `CH_BANG;
              rlen = 4'h2;
            end else if (hex_val(buf_reg[3]) <= 4'h1) begin
              r[0] = `CH_GT;
              rlen = 4'h2;
              set_out = 1'b1;
            end // keeps the invalid reply
          end else
            send = 1'b0;
        end
        `CH_TILDE: begin
          if (frame_len_reg == 4'h4 && buf_reg[3] == `CH_D) begin
            r[0] = `CH_BANG;
            r[3] = `CH_ZERO;
            r[4] = hex_chr({2'b00, pol_reg, 1'b0});
            rlen = 4'h6;
          end else if (frame_len_reg == 4'h6 && buf_reg[3] == `CH_D &&
                       is_hex(buf_reg[4]) && is_hex(buf_reg[5])) begin
            r[0] = `CH_BANG;
            r[3] = buf_reg[4];
            r[4] = buf_reg[5];
            rlen = 4'h6;
            set_pol = 1'b1;
          end else
            send = 1'b0;
        end
        default: send = 1'b0;
      endcase
      if (send)
        r[rlen[2:0] - 3'h1] = `CH_CR;
    end
  end

  // Sequencer: receive, execute once, transmit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg  <= ST_RX;
      tx_len_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_RX: if (frame_end) state_reg <= ST_EXEC;
        ST_EXEC: begin
          tx_idx_reg <= 4'h0;
          tx_len_reg <= rlen;
          for (int i = 0; i < `BUF_LEN; i++)
            tx_buf_reg[i] <= r[i];
          state_reg <= send ? ST_TX : ST_RX;
        end
        ST_TX: if (tx_ready) begin
          if (tx_idx_reg == tx_len_reg - 4'h1)
            state_reg <= ST_RX;
          tx_idx_reg <= tx_idx_reg + 4'h1;
        end
        default: state_reg <= ST_RX;
      endcase
    end
  end
  assign tx_valid = (state_reg == ST_TX);
  assign tx_data  = tx_buf_reg[tx_idx_reg[2:0]];

  // Output channel, forced safe after watchdog timeout
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      out_reg <= 1'b0;
    else if (wdt_timeout)
      out_reg <= SAFE_VALUE[0];
    else if (state_reg == ST_EXEC && set_out)
      out_reg <= data_nib[0];
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      pol_reg <= 1'b0;
    else if (state_reg == ST_EXEC && set_pol)
      pol_reg <= pol_nib[`POL_BIT];
  end
  assign output_value = out_reg;
  assign relay_drive  = out_reg ^ pol_reg;

  // Protocol: stored copy tracks saves, active one latched once after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      proto_loaded_reg <= 1'b0;
      stored_proto_reg <= 2'h0;
      active_proto     <= 2'h0;
      nv_proto_write   <= 1'b0;
      nv_proto_data    <= 2'h0;
    end else begin
      nv_proto_write <= 1'b0;
      if (!proto_loaded_reg) begin
        proto_loaded_reg <= 1'b1;
        stored_proto_reg <= stored_proto_in;
        active_proto     <= stored_proto_in;
      end else if (state_reg == ST_EXEC && save_proto) begin
        stored_proto_reg <= buf_reg[4][1:0];
        nv_proto_data    <= buf_reg[4][1:0];
        nv_proto_write   <= 1'b1;
      end
    end
  end
  assign wdt_clear = (state_reg == ST_EXEC) && alive;

  // Checks
  property p_silent_rx;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(tx_valid) |-> $past(rx_valid && rx_data == `CH_CR, 2);
  endproperty
  a_silent_rx: assert property (p_silent_rx) else $error("reply without a frame");
  property p_alive_quiet;
    @(posedge clk_sys) disable iff (!rst_n) wdt_clear |=> !tx_valid;
  endproperty
  a_alive_quiet: assert property (p_alive_quiet) else $error("reply to host-alive");
  property p_safe;
    @(posedge clk_sys) disable iff (!rst_n) wdt_timeout |=> out_reg == SAFE_VALUE[0];
  endproperty
  a_safe: assert property (p_safe) else $error("output not safe");
  property p_relay;
    @(posedge clk_sys) disable iff (!rst_n) relay_drive == (output_value != pol_reg);
  endproperty
  a_relay: assert property (p_relay) else $error("relay sense wrong");
  property p_saved_code;
    @(posedge clk_sys) disable iff (!rst_n) nv_proto_write |-> nv_proto_data != 2'h2;
  endproperty
  a_saved_code: assert property (p_saved_code) else $error("bad code saved");
  property p_active_held;
    @(posedge clk_sys) disable iff (!rst_n) proto_loaded_reg |=> $stable(active_proto);
  endproperty
  a_active_held: assert property (p_active_held) else $error("active protocol moved");
  property p_reply_cr;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_valid && tx_ready && tx_idx_reg == tx_len_reg - 4'h1 |-> tx_data == `CH_CR;
  endproperty
  a_reply_cr: assert property (p_reply_cr) else $error("reply not closed by CR");
endmodule : ascii_output_cmd

//--- ascii_output_command_interpreter_bench.sv
// Self-checking bench for the ASCII output command interpreter
`timescale 1ns/1ps
module ascii_output_command_interpreter_bench;
  logic       clk_sys, rst_n, unlock_switch, wdt_timeout;
  logic [7:0] module_addr;
  logic [1:0] stored_proto_in = 2'h0;
  wire  [7:0] rx_data, tx_data;
  wire        rx_valid, rx_error, tx_valid, tx_ready, nv_proto_write, wdt_clear;
  wire  [1:0] active_proto, nv_proto_data;
  wire        output_value, relay_drive;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         n_alive = 0;
  string      ps = "103";

  ascii_output_cmd #(.SAFE_VALUE(8'h00)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .module_addr(module_addr), .unlock_switch(unlock_switch),
    .stored_proto_in(stored_proto_in), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_error(rx_error), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .active_proto(active_proto), .nv_proto_data(nv_proto_data),
    .nv_proto_write(nv_proto_write), .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
    .output_value(output_value), .relay_drive(relay_drive));
  host_model u_host (.clk_sys(clk_sys), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_error(rx_error));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Nonvolatile store model and count of watchdog clears
  always @(posedge clk_sys) begin
    if (nv_proto_write === 1'b1) stored_proto_in <= nv_proto_data;
    if (wdt_clear === 1'b1) n_alive <= n_alive + 1;
  end

  task results;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Send one frame and compare the whole reply, CR included
  task cmd(input string c, input string exp, input bit err = 0);
    string r;
    u_host.send(c, err);
    u_host.recv(r);
    if (exp.len() > 0) exp = {exp, "\015"};
    n_tests++;
    if (r != exp) begin
      n_mismatch++;
      $display("[ERR] reply to %s expected %s seen %s", c, exp, r);
    end
  endtask : cmd

  initial begin
    #(40 * 20000);
    n_mismatch++;
    results;
  end
  initial begin
    rst_n = 1'b0;
    unlock_switch = 1'b0;
    wdt_timeout = 1'b0;
    module_addr = 8'h01;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    cmd("@011", ">");
    chk("relay_drive", 8'h01, relay_drive);
    cmd("@01", ">1");
    cmd("@019", "?01");
    chk("output_value", 8'h01, output_value);
    cmd("@010", ">");
    cmd("@021", "");
    cmd("@0011", "", 1);
    chk("output_value", 8'h00, output_value);
    u_host.slow = 1'b1;
    cmd("$01P1", "?01");
    u_host.slow = 1'b0;
    unlock_switch = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cmd({"$01P", ps.substr(i, i)}, "!01");
      cmd("$01P", {"!013", ps.substr(i, i)});
    end
    cmd("$01P2", "?01");
    chk("active_proto", 8'h00, active_proto);
    cmd("~01D02", "!0102");
    chk("relay_drive", 8'h01, relay_drive);
    cmd("~01D", "!0102");
    cmd("~01D00", "!0100");
    cmd("~**", "");
    chk("wdt_clear", 8'h01, 8'(n_alive));
    cmd("~**", "");
    chk("wdt_clear", 8'h02, 8'(n_alive));
    module_addr = 8'hFF;
    cmd("@FF1", ">");
    cmd("@01", "");
    module_addr = 8'h01;
    wdt_timeout = 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("output_value", 8'h00, output_value);
    cmd("@011", "!");
    chk("output_value", 8'h00, output_value);
    wdt_timeout = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("active_proto", 8'h03, active_proto);
    results;
  end
endmodule : ascii_output_command_interpreter_bench

//--- cmd_interp_params.svh
// Constants for the ASCII output command interpreter
`ifndef CMD_INTERP_PARAMS_SVH
`define CMD_INTERP_PARAMS_SVH
`define CH_CR        8'h0D
`define CH_DOLLAR    8'h24
`define CH_AT        8'h40
`define CH_TILDE     8'h7E
`define CH_STAR      8'h2A
`define CH_BANG      8'h21
`define CH_QUEST     8'h3F
`define CH_GT        8'h3E
`define CH_P         8'h50
`define CH_D         8'h44
`define CH_ZERO      8'h30
`define PROTO_NATIVE 2'h0
`define PROTO_RTU    2'h1
`define PROTO_MASCII 2'h3
`define PROTO_SUPPORTED 4'h3
`define POL_BIT      1
`define BUF_LEN      8
`endif

//--- cmd_interp_pkg.sv
// Types for the ASCII output command interpreter
package cmd_interp_pkg;
  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} state_e;
  typedef logic [7:0] char_t;
endpackage : cmd_interp_pkg

//--- host_model.sv
// Host controller model that sends command frames and collects replies
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_error
);
  logic slow;
  initial begin
    slow = 1'b0;
    tx_ready = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_error = 1'b0;
  end
  // One char per cycle, closed by CR; err drops char 1 as a line error
  task send(input string s, input bit err);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_sys);
      #1;
      rx_data = s[i];
      rx_valid = !(err && i == 1);
      rx_error = err && i == 1;
    end
    @(posedge clk_sys);
    #1;
    rx_data = 8'h0D;
    rx_valid = 1'b1;
    rx_error = 1'b0;
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    rx_data = 8'hF2; // Idle line shows no stale char
  endtask : send
  // Collect reply chars up to CR; a slow host only accepts every third cycle
  task recv(output string r);
    logic       hv;
    logic [7:0] hd;
    r = "";
    hv = 1'b0;
    hd = 8'h00;
    for (int w = 0; w < 60; w++) begin
      @(posedge clk_sys);
      if (hv) r = {r, string'(hd)};
      if (hv && hd == 8'h0D) break;
      #1;
      tx_ready = !slow || (w % 3 == 0);
      hv = tx_valid && tx_ready;
      hd = tx_data;
    end
    #1;
    tx_ready = 1'b0;
  endtask : recv
endmodule : host_model
